// [verilog/headerless_sector_tracker.sv]
// head position tracker, control four options and disk interrupt-0 status
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
module headerless_sector_tracker (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // disk pins
   input wire logic servo_end_pulse,
   input wire logic index_pin,
   input wire logic write_fault_pin,
   // sequencer side
   input wire logic seq_start,
   input wire logic [2:0] seq_code,
   input wire logic [3:0] sequencer_count_field,
   input wire logic split_counter_reset,
   input wire logic [9:0] requested_sector_number,
   input wire logic [9:0] wrap_sector_number,
   output logic head_at_request_flag,
   output logic frame_at_target_flag,
   output logic frame_at_maximum_flag,
   output logic request_at_wrap_flag,
   output logic seq_running,
   output logic seed_transfer_start,
   output logic corrector_init,
   output logic sync_write_mark,
   output logic seed_queue_reset,
   output logic sector_release_block,
   // event inputs
   input wire logic seed_sector_corrected,
   input wire logic seed_queue_read,
   input wire logic auto_write_seen,
   input wire logic split_parity_error,
   input wire logic seed_mismatch_error,
   input wire logic servo_fetch_overrun,
   input wire logic soft_correctable_error,
   input wire logic data_compare_mismatch,
   // split queue fill side and split counter
   input wire logic split_push_valid,
   input wire logic [15:0] split_push_count,
   input wire logic split_push_last,
   input wire logic split_counts_from_buffer,
   output logic split_fetch_request,
   input wire logic split_tick,
   output logic [15:0] split_count,
   output logic split_loaded,
   // interrupt
   output logic disk_irq0_active
);
   import sector_tracker_pkg::*;
   //////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [7:0] frame_counter;
      logic [7:0] frame_maximum;
      logic [9:0] head_sector;
      logic [7:0] frame_target;
      logic [7:0] control_four;
      logic [7:0] irq_status;
      logic [7:0] irq_enable;
      logic [2:0] chip_config;
      logic target_passed;
      seq_state_type seq;
      logic [1:0] seed_pending;
      logic index_prev;
      logic fault_prev;
      logic release_block;
      logic [7:0] rdata;
   } tracker_state_type;
   tracker_state_type state, next_state;
   logic servo_lvl, index_lvl, fault_lvl;
   logic servo_edge, index_edge, fault_edge;
   logic servo_prev_q;
   logic frame_clear, frame_wrap, halt, swap;
   logic [7:0] addr_eff, clear_mask, set_mask;

   pin_sync servo_sync (
      .core_clk(core_clk), .arst_n(arst_n), .pin(servo_end_pulse), .level(servo_lvl));
   pin_sync index_sync (
      .core_clk(core_clk), .arst_n(arst_n), .pin(index_pin), .level(index_lvl));
   pin_sync fault_sync (
      .core_clk(core_clk), .arst_n(arst_n), .pin(write_fault_pin), .level(fault_lvl));

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         servo_prev_q <= 1'b0;
      end else begin
         servo_prev_q <= servo_lvl;
      end
   end

   split_queue split_unit (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .enhanced_headerless_enable(state.control_four[C4_ENHANCED]),
      .split_counts_from_buffer(split_counts_from_buffer),
      .push_valid(split_push_valid),
      .push_count(split_push_count),
      .push_last(split_push_last),
      .fetch_request(split_fetch_request),
      .load_split_command(state.seq == SEQ_RUN && seq_code == CODE_LOAD_SPLIT),
      .sequencer_count_field(sequencer_count_field),
      .split_counter_reset(split_counter_reset),
      .count_tick(split_tick),
      .split_count(split_count),
      .counter_loaded(split_loaded)
   );

   //////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_state = state;
      servo_edge = servo_lvl && !servo_prev_q;
      index_edge = index_lvl && !state.index_prev;
      fault_edge = fault_lvl && !state.fault_prev;
      next_state.index_prev = index_lvl;
      next_state.fault_prev = fault_lvl;
      swap = state.chip_config[CC_SWAP];
      // with swap the high byte answers at the lower address
      addr_eff = reg_addr;
      if (swap && reg_addr == OFS_SECTOR_LOW) begin
         addr_eff = OFS_SECTOR_HIGH;
      end else if (swap && reg_addr == OFS_SECTOR_HIGH) begin
         addr_eff = OFS_SECTOR_LOW;
      end
      frame_clear = state.control_four[C4_IDX_CLR] && index_edge;
      frame_wrap = servo_edge && (state.frame_counter == state.frame_maximum);
      // target passed is set only while the sequencer runs, and is kept after it stops
      if (servo_edge && state.frame_counter == state.frame_target
          && state.seq == SEQ_RUN) begin
         next_state.target_passed = 1'b1;
      end
      // the index clear outranks a same-cycle increment
      if (frame_clear) begin
         next_state.frame_counter = 8'h00;
      end else if (frame_wrap) begin
         next_state.frame_counter = 8'h00;
      end else if (servo_edge) begin
         next_state.frame_counter = state.frame_counter + 8'h01;
      end
      if ((frame_clear || frame_wrap) && state.target_passed) begin
         next_state.head_sector = 10'h000;
         next_state.target_passed = 1'b0;
      end
      // seed queue occupancy, reset while seed is off
      if (!state.control_four[C4_SEED_EN]) begin
         next_state.seed_pending = 2'h0;
      end else if (seed_sector_corrected && !seed_queue_read
                   && state.seed_pending != 2'h3) begin
         next_state.seed_pending = state.seed_pending + 2'h1;
      end else if (seed_queue_read && !seed_sector_corrected
                   && state.seed_pending != 2'h0) begin
         next_state.seed_pending = state.seed_pending - 2'h1;
      end
      if (seed_mismatch_error) begin
         next_state.release_block = 1'b1;
      end else if (state.seq == SEQ_RUN && seq_code == CODE_DATA_INIT) begin
         next_state.release_block = 1'b0;
      end
      // status events
      set_mask = 8'h00;
      set_mask[ST_SRV_OVR] = servo_fetch_overrun;
      set_mask[ST_SOFT] = soft_correctable_error;
      set_mask[ST_HIT] = state.seq == SEQ_RUN && seq_code == CODE_DATA_INIT;
      set_mask[ST_CMP] = data_compare_mismatch;
      set_mask[ST_WFLT] = state.seq == SEQ_RUN && fault_edge
                          && state.chip_config[CC_WFLT];
      halt = servo_fetch_overrun || set_mask[ST_WFLT]
         || (state.control_four[C4_SEED_OVR]
             && state.seed_pending > 2'(SEED_QUEUE_LIMIT))
         || (state.control_four[C4_AUTO_WR] && auto_write_seen)
         || (state.control_four[C4_SPLIT_PERR] && split_parity_error)
         || (state.control_four[C4_SEED_ERR] && seed_mismatch_error);
      case (state.seq)
         SEQ_IDLE: begin
            if (seq_start) begin
               next_state.seq = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            if (halt) begin
               next_state.seq = SEQ_HALT;
            end
         end
         SEQ_HALT: begin
            if (seq_start && !halt) begin
               next_state.seq = SEQ_RUN;
            end
         end
         default: begin
            next_state.seq = SEQ_IDLE;
         end
      endcase
      clear_mask = 8'h00;
      // register writes; leaves collision with pulses to software
      if (reg_write) begin
         case (addr_eff)
            OFS_FRAME_COUNTER: next_state.frame_counter = reg_wdata;
            OFS_FRAME_MAXIMUM: next_state.frame_maximum = reg_wdata;
            OFS_SECTOR_LOW: next_state.head_sector[7:0] = reg_wdata;
            OFS_SECTOR_HIGH: next_state.head_sector[9:8] = reg_wdata[1:0];
            OFS_FRAME_TARGET: next_state.frame_target = reg_wdata;
            OFS_CONTROL_FOUR: next_state.control_four = reg_wdata & C4_WRITABLE;
            OFS_IRQ0_STATUS: clear_mask = reg_wdata & ST_USED;
            OFS_IRQ0_ENABLE: next_state.irq_enable = reg_wdata & ST_USED;
            OFS_CHIP_CONFIG: next_state.chip_config = reg_wdata[2:0];
            default: begin
            end
         endcase
      end
      // set wins over a same-cycle clear
      next_state.irq_status = (state.irq_status & ~clear_mask) | set_mask;
      next_state.rdata = 8'h00;
      if (reg_read) begin
         case (addr_eff)
            OFS_FRAME_COUNTER: next_state.rdata = state.frame_counter;
            OFS_FRAME_MAXIMUM: next_state.rdata = state.frame_maximum;
            OFS_SECTOR_LOW: next_state.rdata = state.head_sector[7:0];
            OFS_SECTOR_HIGH: next_state.rdata = {head_at_request_flag,
               frame_at_target_flag, frame_at_maximum_flag, request_at_wrap_flag,
               2'b00, state.head_sector[9:8]};
            OFS_FRAME_TARGET: next_state.rdata = state.frame_target;
            OFS_CONTROL_FOUR: next_state.rdata = state.control_four;
            OFS_IRQ0_STATUS: next_state.rdata = state.irq_status;
            OFS_IRQ0_ENABLE: next_state.rdata = state.irq_enable;
            OFS_CHIP_CONFIG: next_state.rdata = {5'h00, state.chip_config};
            default: next_state.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   assign head_at_request_flag = state.head_sector == requested_sector_number;
   // compare is combinational so the sequencer sees it in the pulse cycle
   assign frame_at_target_flag = servo_edge
      && state.frame_counter == state.frame_target;
   assign frame_at_maximum_flag = state.frame_counter == state.frame_maximum;
   assign request_at_wrap_flag = wrap_sector_number == requested_sector_number;
   assign seq_running = state.seq == SEQ_RUN;
   assign seed_transfer_start = seq_running && state.control_four[C4_SEED_EN]
      && seq_code == CODE_CORR_INIT;
   assign corrector_init = seq_running && ((state.control_four[C4_SEED_EN]
      && seq_code == CODE_CORR_INIT) || (!state.control_four[C4_SEED_EN]
      && seq_code == CODE_DATA_INIT));
   assign sync_write_mark = seq_running && state.control_four[C4_SEED_EN]
      && seq_code == CODE_DATA_INIT;
   assign seed_queue_reset = !state.control_four[C4_SEED_EN];
   assign sector_release_block = state.release_block;
   assign disk_irq0_active = state.chip_config[CC_IRQ_EN]
      && |(state.irq_status & state.irq_enable);
   assign reg_rdata = state.rdata;
endmodule : headerless_sector_tracker
`default_nettype wire

// [verilog/sector_tracker_pkg.sv]
// constants for the headerless sector tracker
package sector_tracker_pkg;
   localparam logic [7:0] OFS_FRAME_COUNTER = 8'h58;
   localparam logic [7:0] OFS_FRAME_MAXIMUM = 8'h59;
   localparam logic [7:0] OFS_SECTOR_LOW = 8'h5a;
   localparam logic [7:0] OFS_SECTOR_HIGH = 8'h5b;
   localparam logic [7:0] OFS_FRAME_TARGET = 8'h5c;
   localparam logic [7:0] OFS_CONTROL_FOUR = 8'h5d;
   localparam logic [7:0] OFS_IRQ0_STATUS = 8'h5e;
   localparam logic [7:0] OFS_IRQ0_ENABLE = 8'h5f;
   localparam logic [7:0] OFS_CHIP_CONFIG = 8'h60;
   // control four fields
   localparam int C4_SEED_OVR = 6;
   localparam int C4_AUTO_WR = 5;
   localparam int C4_SEED_EN = 4;
   localparam int C4_SPLIT_PERR = 3;
   localparam int C4_SEED_ERR = 2;
   localparam int C4_IDX_CLR = 1;
   localparam int C4_ENHANCED = 0;
   localparam logic [7:0] C4_WRITABLE = 8'h7f;
   // chip config fields (swap, irq0 chip enable, write fault halt)
   localparam int CC_SWAP = 0;
   localparam int CC_IRQ_EN = 1;
   localparam int CC_WFLT = 2;
   // high sector flag positions
   localparam int HF_AT_REQ = 7;
   localparam int HF_AT_TGT = 6;
   localparam int HF_AT_MAX = 5;
   localparam int HF_WRAP = 4;
   // interrupt-0 status bits
   localparam int ST_SRV_OVR = 7;
   localparam int ST_SOFT = 4;
   localparam int ST_HIT = 3;
   localparam int ST_CMP = 1;
   localparam int ST_WFLT = 0;
   localparam logic [7:0] ST_USED = 8'h9b;
   // sequencer codes
   localparam logic [2:0] CODE_LOAD_SPLIT = 3'b001;
   localparam logic [2:0] CODE_DATA_INIT = 3'b011;
   localparam logic [2:0] CODE_CORR_INIT = 3'b100;
   localparam int SEED_QUEUE_LIMIT = 2;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_RUN = 2'b01,
      SEQ_HALT = 2'b11
   } seq_state_type;
endpackage : sector_tracker_pkg

// [verilog/pin_sync.sv]
// three-stage synchroniser with second/third agreement
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // pin and clean level
   input wire logic pin,
   output logic level
);
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } sync_state_type;
   sync_state_type state, next_state;
   always_comb begin
      next_state = state;
      next_state.stage = {state.stage[1:0], pin};
      // first stage feeds only the second
      if (state.stage[1] == state.stage[2]) begin
         next_state.level = state.stage[2];
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign level = state.level;
endmodule : pin_sync
`default_nettype wire

// [verilog/split_queue.sv]
// split-count queue and split counter
`timescale 1ns/1ns
`default_nettype none
module split_queue (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // mode
   input wire logic enhanced_headerless_enable,
   input wire logic split_counts_from_buffer,
   // fill side
   input wire logic push_valid,
   input wire logic [15:0] push_count,
   input wire logic push_last,
   output logic fetch_request,
   // commands
   input wire logic load_split_command,
   input wire logic [3:0] sequencer_count_field,
   input wire logic split_counter_reset,
   // counter
   input wire logic count_tick,
   output logic [15:0] split_count,
   output logic counter_loaded
);
   localparam int DEPTH = 4;
   typedef struct packed {
      logic [DEPTH-1:0][16:0] slot;
      logic [1:0] rd;
      logic [1:0] wr;
      logic [2:0] used;
      logic [3:0] owed;
      logic flushing;
      logic [15:0] counter;
      logic loaded;
      logic cur_last;
      logic stopped;
   } queue_state_type;
   queue_state_type state, next_state;
   logic take, pop, full;
   always_comb begin
      next_state = state;
      full = (state.used == 3'(DEPTH));
      take = push_valid && !full;
      pop = 1'b0;
      if (enhanced_headerless_enable) begin
         fetch_request = split_counts_from_buffer && !full;
      end else begin
         fetch_request = split_counts_from_buffer && (state.owed != 4'h0) && !full;
      end
      if (take) begin
         next_state.slot[state.wr] = {push_last, push_count};
         next_state.wr = state.wr + 2'h1;
         if (state.owed != 4'h0) begin
            next_state.owed = state.owed - 4'h1;
         end
      end
      if (state.loaded && count_tick) begin
         next_state.counter = state.counter - 16'h1;
         if (state.counter == 16'h1) begin
            next_state.loaded = 1'b0;
            if (enhanced_headerless_enable && state.cur_last) begin
               next_state.stopped = 1'b1;
            end
         end
      end
      // enhanced flush drops entries through the first last-marked one
      if (state.flushing && state.used != 3'h0) begin
         pop = 1'b1;
         if (state.slot[state.rd][16]) begin
            next_state.flushing = 1'b0;
         end
      end else if (state.flushing) begin
         next_state.flushing = 1'b0;
      end else if (!state.loaded && state.used != 3'h0 && !state.stopped) begin
         pop = 1'b1;
         next_state.counter = state.slot[state.rd][15:0];
         next_state.cur_last = state.slot[state.rd][16];
         next_state.loaded = 1'b1;
      end
      if (pop) begin
         next_state.rd = state.rd + 2'h1;
      end
      next_state.used = state.used + 3'(take) - 3'(pop);
      if (load_split_command || split_counter_reset) begin
         next_state.loaded = 1'b0;
         next_state.counter = 16'h0;
         next_state.stopped = 1'b0;
         if (load_split_command && enhanced_headerless_enable) begin
            next_state.flushing = 1'b1;
         end else begin
            next_state.rd = 2'h0;
            next_state.wr = 2'h0;
            next_state.used = 3'h0;
            next_state.flushing = 1'b0;
            if (load_split_command) begin
               next_state.owed = sequencer_count_field;
            end
         end
      end
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end
   assign split_count = state.counter;
   assign counter_loaded = state.loaded;
endmodule : split_queue
`default_nettype wire

// [verification/tracker_checker.sv]
// port assertions for the headerless sector tracker
`timescale 1ns/1ns
`default_nettype none
module tracker_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // register port
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // sequencer side
   input wire logic seq_start,
   input wire logic [2:0] seq_code,
   input wire logic seq_running,
   input wire logic seed_transfer_start,
   input wire logic corrector_init,
   input wire logic sync_write_mark,
   input wire logic seed_queue_reset,
   input wire logic sector_release_block,
   input wire logic seed_mismatch_error,
   input wire logic servo_fetch_overrun,
   // sector compare
   input wire logic [9:0] requested_sector_number,
   input wire logic [9:0] wrap_sector_number,
   input wire logic request_at_wrap_flag
);
   import sector_tracker_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   //////////////////////////////////////////////////////////////////////////////
   read_slot_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   wrap_flag_a: assert property (request_at_wrap_flag == (requested_sector_number == wrap_sector_number))
      else $error("wrap compare flag wrong");
   seed_start_a: assert property (seed_transfer_start |-> seq_code == CODE_CORR_INIT && !seed_queue_reset)
      else $error("seed start without seed code");
   corr_init_a: assert property (corrector_init |-> (seq_code == CODE_CORR_INIT && !seed_queue_reset) ||
      (seq_code == CODE_DATA_INIT && seed_queue_reset)) else $error("corrector init on wrong code");
   sync_mark_a: assert property (sync_write_mark |-> seq_code == CODE_DATA_INIT && !seed_queue_reset)
      else $error("sync mark on wrong code");
   release_set_a: assert property (seed_mismatch_error && seq_code != CODE_DATA_INIT |=> sector_release_block)
      else $error("seed error did not hold the sector");
   release_hold_a: assert property ($fell(sector_release_block) |-> $past(seq_code) == CODE_DATA_INIT)
      else $error("sector hold dropped without data init");
   overrun_halt_a: assert property (seq_running && servo_fetch_overrun && !seq_start |=> !seq_running)
      else $error("servo overrun did not halt");
endmodule : tracker_checker
bind headerless_sector_tracker tracker_checker tracker_checker_i (.core_clk, .arst_n, .reg_read,
   .reg_rdata, .seq_start, .seq_code, .seq_running, .seed_transfer_start, .corrector_init,
   .sync_write_mark, .seed_queue_reset, .sector_release_block, .seed_mismatch_error,
   .servo_fetch_overrun, .requested_sector_number, .wrap_sector_number, .request_at_wrap_flag);
`default_nettype wire

// [verification/disk_pin_model.sv]
// disk pin model: servo end, index and write fault pins
`timescale 1ns/1ns
`default_nettype none
module disk_pin_model (
   // clock and request: bit0 servo end, bit1 index, bit2 write fault
   input wire logic core_clk,
   input wire logic [2:0] fire,
   // pins, high while active, low when idle
   output logic servo_end_pulse,
   output logic index_pin,
   output logic write_fault_pin
);
   // held four cycles, a shorter pulse could slip past the synchroniser
   logic [2:0] hold [3] = '{3'h0, 3'h0, 3'h0};
   always @(posedge core_clk) begin
      for (int i = 0; i < 3; i++) begin
         hold[i] <= fire[i] ? 3'h4 : hold[i] - 3'(hold[i] != 3'h0);
      end
   end
   assign servo_end_pulse = hold[0] != 3'h0;
   assign index_pin = hold[1] != 3'h0;
   assign write_fault_pin = hold[2] != 3'h0;
endmodule : disk_pin_model
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the headerless sector tracker
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic core_clk, arst_n, reg_write, reg_read, seq_start, servo_end_pulse, index_pin;
   logic write_fault_pin, head_at_request_flag, seq_running, seed_transfer_start;
   logic corrector_init, sync_write_mark, seed_queue_reset, sector_release_block, disk_irq0_active;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, ev;
   logic [2:0] seq_code, fire;
   logic [9:0] requested_sector_number, wrap_sector_number;
   logic split_push_valid, split_loaded;
   logic [15:0] split_push_count, split_count;
   int n_errors = 0;
   int tests_run = 0;
   // step word: op, address or mask, data or expectation
   wire [7:0] obs = {disk_irq0_active, head_at_request_flag, seq_running, sector_release_block,
      seed_transfer_start, corrector_init, sync_write_mark, seed_queue_reset};
   disk_pin_model disk_pin_model_i (.core_clk, .fire, .servo_end_pulse, .index_pin, .write_fault_pin);
   headerless_sector_tracker headerless_sector_tracker_i (.core_clk, .arst_n, .reg_addr,
      .reg_wdata, .reg_write, .reg_read, .reg_rdata, .servo_end_pulse, .index_pin,
      .write_fault_pin, .seq_start, .seq_code, .sequencer_count_field(4'h0),
      .split_counter_reset(1'b0), .requested_sector_number, .wrap_sector_number,
      .head_at_request_flag, .frame_at_target_flag(), .frame_at_maximum_flag(),
      .request_at_wrap_flag(), .seq_running, .seed_transfer_start, .corrector_init,
      .sync_write_mark, .seed_queue_reset, .sector_release_block, .seed_sector_corrected(ev[0]),
      .seed_queue_read(ev[1]), .auto_write_seen(ev[2]), .split_parity_error(ev[3]),
      .seed_mismatch_error(ev[4]), .servo_fetch_overrun(ev[5]), .soft_correctable_error(ev[6]),
      .data_compare_mismatch(ev[7]), .split_push_valid, .split_push_count,
      .split_push_last(1'b0), .split_counts_from_buffer(1'b0), .split_fetch_request(),
      .split_tick(1'b0), .split_count, .split_loaded, .disk_irq0_active);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   //////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // 0 read, 1 write, 2 pins, 3 events, 4 start, 5 code, 6 outputs, 7 wrap sector
   task automatic run(input logic [19:0] s);
      logic [3:0] op;
      op = s[19:16];
      @(posedge core_clk);
      reg_addr <= s[15:8];
      reg_wdata <= s[7:0];
      reg_read <= op == 4'h0;
      reg_write <= op == 4'h1;
      if (op == 4'h2) fire <= s[2:0];
      if (op == 4'h3) ev <= s[7:0];
      if (op == 4'h4) seq_start <= 1'b1;
      if (op == 4'h5) seq_code <= s[10:8];
      if (op == 4'h7) wrap_sector_number <= s[9:0];
      @(posedge core_clk);
      {reg_read, reg_write, fire, ev, seq_start} <= '0;
      if (op == 4'h2) repeat (10) @(posedge core_clk);
      #1;
      if (op == 4'h0) chk(reg_rdata, s[7:0]);
      if (op == 4'h5) chk(obs & 8'h0f, s[7:0]);
      if (op == 4'h6) chk(obs & s[15:8], s[7:0]);
   endtask : run
   task automatic t_regs;
      logic [19:0] s [] = '{20'h05b20, 20'h05e00, 20'h15dff, 20'h05d7f, 20'h15fff, 20'h05f9b,
         20'h140ff, 20'h04000, 20'h15f00, 20'h15d00, 20'h15902, 20'h15c01, 20'h05c01};
      foreach (s[i]) run(s[i]);
   endtask : t_regs
   task automatic t_frame;
      logic [19:0] s [] = '{20'h20001, 20'h05801, 20'h20001, 20'h05b20, 20'h20001, 20'h05800,
         20'h15801, 20'h20002, 20'h05801, 20'h15d02, 20'h20002, 20'h05800,
         20'h15801, 20'h20003, 20'h05800, 20'h15d00};
      foreach (s[i]) run(s[i]);
   endtask : t_frame
   task automatic t_sector;
      logic [19:0] s [] = '{20'h15a34, 20'h15bfe, 20'h05a34, 20'h05b82, 20'h64040,
         20'h70234, 20'h16001, 20'h05a92, 20'h15a01, 20'h05b34, 20'h05a11, 20'h16000,
         20'h70000, 20'h15901, 20'h15c00, 20'h20001, 20'h20001, 20'h05a34,
         20'h40000, 20'h20001, 20'h20001, 20'h05a00, 20'h05b00};
      foreach (s[i]) run(s[i]);
   endtask : t_sector
   task automatic t_codes;
      logic [19:0] s [] = '{20'h15d10, 20'h5040c, 20'h50302, 20'h15d00, 20'h50305,
         20'h05e08,
         20'h50401, 20'h30010, 20'h63030, 20'h50305, 20'h50001, 20'h61000};
      foreach (s[i]) run(s[i]);
   endtask : t_codes
   task automatic t_irq;
      logic [19:0] s [] = '{20'h15eff, 20'h05e00, 20'h300c0, 20'h05e12, 20'h16002,
         20'h68000, 20'h15f10, 20'h68080, 20'h15e00, 20'h05e12, 20'h15e10,
         20'h05e02, 20'h68000, 20'h15f00};
      foreach (s[i]) run(s[i]);
   endtask : t_irq
   task automatic t_halt;
      logic [19:0] s [] = '{20'h15d20, 20'h40000, 20'h30004, 20'h62000,
         20'h15d08, 20'h40000, 20'h30008, 20'h62000, 20'h15d04, 20'h40000, 20'h30010,
         20'h62000, 20'h15d00, 20'h40000, 20'h30020, 20'h62000, 20'h40000, 20'h30004,
         20'h62020, 20'h15d50, 20'h40000, 20'h30001, 20'h30001, 20'h62020, 20'h30001,
         20'h62000, 20'h15d00, 20'h16004, 20'h40000, 20'h20004, 20'h62000,
         20'h16000, 20'h05e83};
      foreach (s[i]) run(s[i]);
   endtask : t_halt
   // one pushed count must reach the empty counter
   task automatic t_split;
      @(posedge core_clk);
      split_push_valid <= 1'b1;
      split_push_count <= 16'h1234;
      @(posedge core_clk);
      split_push_valid <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(split_count[15:8], 8'h12);
      chk(split_count[7:0], 8'h34);
      chk({7'h00, split_loaded}, 8'h01);
   endtask : t_split
   task automatic stop_test;
      if (n_errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : stop_test
   initial begin
      {arst_n, reg_write, reg_read, seq_start, reg_addr, reg_wdata, ev, seq_code, fire} = '0;
      {split_push_valid, split_push_count} = '0;
      wrap_sector_number = 10'h000;
      requested_sector_number = 10'h234;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'b1;
      t_regs();
      t_frame();
      t_sector();
      t_codes();
      t_irq();
      t_halt();
      t_split();
      stop_test();
   end
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
endmodule : testbench
`default_nettype wire
